/* File: hdl/usart_defs.svh */
`ifndef USART_DEFS_SVH
`define USART_DEFS_SVH

// ==========================================================
// Register indices; byte address is four times the index
`define IDX_RCV_STAT 6'h13
`define IDX_RCV_FIFO 6'h14
`define IDX_TX_STAT 6'h15
`define IDX_TX_BUF 6'h16
`define IDX_BAUD 6'h17
`define IDX_BANK1 6'h20
`define IDX_IRQ_FLAGS (`IDX_BANK1 | 6'h16)
`define IDX_IRQ_EN (`IDX_BANK1 | 6'h17)

// ==========================================================
// Receive status/control fields
`define RS_PORT_EN 7
`define RS_NINE_RX 6
`define RS_SINGLE 5
`define RS_CONT 4
`define RS_FRAME 2
`define RS_OVERRUN 1
`define RS_BIT9 0

// ==========================================================
// Transmit status/control fields
`define TS_CLK_SRC 7
`define TS_NINE_TX 6
`define TS_TX_EN 5
`define TS_SYNC 4
`define TS_SHIFT_EMPTY 1
`define TS_BIT9 0

// ==========================================================
// Flag / enable fields and reset values
`define IRQ_BUF_EMPTY 1
`define IRQ_DATA_READY 0
`define RST_IRQ_EN 8'h00
`define RST_BAUD 8'h00
`define WORD8_BITS 4'h8
`define WORD9_BITS 4'h9
`define FIFO_DEPTH 2'h2

`endif

/* File: hdl/usart_pkg.sv */
package usart_pkg;

  // One queued receive word with its status
  typedef struct packed {
    logic framing_error;
    logic receive_ninth_bit;
    logic [7:0] data;
  } rx_entry_s;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_TX = 2'b01,
    MODE_RX = 2'b10
  } link_mode_e;

endpackage

/* File: hdl/usart_sync_master_port.sv */
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - Half duplex: sending and receiving never happen at the same time.
// - Clocked-mode bit picks synchronous; port enable claims clock and data pins.
// - Clock source bit set makes the port master, driving the shift clock.
// - Shifter reloads from buffer only after its last bit, if buffer full.
// - Buffer-empty flag sets on hand-over, clears only by buffer write.
// - Shifter-empty status bit is read-only and mirrors an idle shifter.
// - Transmit enable allows sending; nothing shifts until buffer holds data.
// - Bits change on shift clock rise, stay stable across the fall.
// - Baud generator held reset while all three enables are clear.
// - Buffer write to an empty shifter moves data through at once.
// - Clearing transmit enable aborts, resets transmitter, floats both pins.
// - Receive enable mid-transfer floats data pin, clock stays driven.
// - Single receive clears itself after one word; sending then resumes.
// - Nine-bit mode; ninth bit latched when buffer moves into shifter.
// - Clearing port or transmit enable resets the transmit logic.
// - Reception starts on either receive enable; sampled on clock falls.
// - Single receive takes one word; continuous runs on and wins.
// - Finished word enters FIFO if room and sets data-ready flag.
// - Receive FIFO holds two words, read back in arrival order.
// - Full FIFO at word end sets overrun, drops word, blocks moves.
// - Ninth bit and framing error queue with each data word.
// - Clearing both receive enables or port enable resets receiver.
`include "usart_defs.svh"

module usart_sync_master_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Shift clock pin
  output logic clock_pin_o,
  output logic clock_pin_en_n_o,
  // Data pin
  input wire logic data_pin_i,
  output logic data_pin_o,
  output logic data_pin_en_n_o
);

  function automatic logic [3:0] word_bits(input logic nine);
    word_bits = nine ? `WORD9_BITS : `WORD8_BITS;
  endfunction

  // ==========================================================
  // Configuration
  logic port_enable_reg, nine_bit_receive_reg;
  logic single_rx_reg, cont_rx_reg;
  logic clock_source_select_reg, nine_bit_transmit_reg;
  logic transmit_enable_reg, clocked_mode_reg, transmit_ninth_bit_reg;
  logic [7:0] baud_divisor_reg, irq_enable_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [5:0] idx;
  logic bus_fire, wr_fire, cont_clear;
  logic port_active, rx_on, tx_go, brg_run;
  usart_pkg::link_mode_e mode;

  assign idx = adr_i[7:2];
  assign bus_fire = cyc_i & stb_i & ack_reg;
  assign wr_fire = bus_fire & we_i & sel_i[0];
  assign cont_clear = wr_fire & (idx == `IDX_RCV_STAT) & cont_rx_reg &
                      ~dat_i[`RS_CONT];
  assign port_active = port_enable_reg & clocked_mode_reg &
                       clock_source_select_reg;
  assign rx_on = port_active & (single_rx_reg | cont_rx_reg);
  assign tx_go = port_active & transmit_enable_reg & ~rx_on;
  assign brg_run = port_active & (transmit_enable_reg | single_rx_reg |
                   cont_rx_reg);
  assign mode = rx_on ? usart_pkg::MODE_RX :
                tx_go ? usart_pkg::MODE_TX : usart_pkg::MODE_OFF;

  // ==========================================================
  // Baud generator and shift clock
  logic [7:0] baud_cnt_reg;
  logic sck_reg, tick, rise_now, fall_now;

  assign tick = brg_run & (baud_cnt_reg == 8'h00);
  assign rise_now = tick & ~sck_reg;
  assign fall_now = tick & sck_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || !brg_run) begin
      baud_cnt_reg <= baud_divisor_reg;
      sck_reg <= 1'b0;
    end else if (tick) begin
      baud_cnt_reg <= baud_divisor_reg;
      sck_reg <= ~sck_reg;
    end else begin
      baud_cnt_reg <= baud_cnt_reg - 8'h01;
    end
  end

  // ==========================================================
  // Data pin synchroniser
  logic din_meta_reg, din_sync_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      din_meta_reg <= 1'b0;
      din_sync_reg <= 1'b0;
    end else begin
      din_meta_reg <= data_pin_i;
      din_sync_reg <= din_meta_reg;
    end
  end

  // ==========================================================
  // Transmitter
  logic [7:0] tx_buf_reg;
  logic tx_buf_full_reg, tx_busy_reg, tx_load, tx_reset;
  logic [8:0] tsr_reg;
  logic [3:0] tx_idx_reg, tx_len_reg;
  logic data_out_reg;

  assign tx_reset = ~port_enable_reg | ~transmit_enable_reg;
  assign tx_load = ~tx_busy_reg & tx_buf_full_reg & ~tx_reset;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_buf_reg <= 8'h00;
      tx_buf_full_reg <= 1'b0;
    end else if (wr_fire && idx == `IDX_TX_BUF) begin
      tx_buf_reg <= dat_i[7:0];
      tx_buf_full_reg <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full_reg <= 1'b0;
    end
  end

  // Frozen rather than reset while a receive holds the pins
  always_ff @(posedge clk_i) begin
    if (rst_i || tx_reset) begin
      tx_busy_reg <= 1'b0;
      tx_idx_reg <= 4'h0;
      tx_len_reg <= `WORD8_BITS;
      tsr_reg <= 9'h000;
    end else if (tx_load) begin
      tx_busy_reg <= 1'b1;
      tx_idx_reg <= 4'h0;
      tx_len_reg <= word_bits(nine_bit_transmit_reg);
      tsr_reg <= {transmit_ninth_bit_reg, tx_buf_reg};
    end else if (tx_busy_reg && tx_go) begin
      if (rise_now && tx_idx_reg != tx_len_reg) begin
        tx_idx_reg <= tx_idx_reg + 4'h1;
      end else if (fall_now && tx_idx_reg == tx_len_reg) begin
        tx_busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_out_reg <= 1'b0;
    end else if (tx_busy_reg && tx_go && rise_now &&
                 tx_idx_reg != tx_len_reg) begin
      data_out_reg <= tsr_reg[tx_idx_reg];
    end
  end

  // ==========================================================
  // Pin drivers
  logic clk_en_n_reg, dat_en_n_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_en_n_reg <= 1'b1;
      dat_en_n_reg <= 1'b1;
    end else begin
      case (mode)
        usart_pkg::MODE_TX: begin
          clk_en_n_reg <= 1'b0;
          dat_en_n_reg <= 1'b0;
        end
        usart_pkg::MODE_RX: begin
          clk_en_n_reg <= 1'b0;
          dat_en_n_reg <= 1'b1;
        end
        default: begin
          clk_en_n_reg <= 1'b1;
          dat_en_n_reg <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Receiver
  logic [8:0] rsr_reg, rx_word;
  logic [3:0] rx_idx_reg, rx_len;
  logic rx_done, rx_reset;

  assign rx_len = word_bits(nine_bit_receive_reg);
  assign rx_reset = ~rx_on;
  assign rx_done = rx_on & fall_now & (rx_idx_reg == rx_len - 4'h1);

  always_comb begin
    rx_word = rsr_reg;
    rx_word[rx_idx_reg] = din_sync_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_reset) begin
      rx_idx_reg <= 4'h0;
      rsr_reg <= 9'h000;
    end else if (fall_now) begin
      rsr_reg <= rx_word;
      rx_idx_reg <= rx_done ? 4'h0 : rx_idx_reg + 4'h1;
    end
  end

  // ==========================================================
  // Receive FIFO
  usart_pkg::rx_entry_s fifo_mem [0:1];
  usart_pkg::rx_entry_s head;
  logic [1:0] fifo_cnt_reg;
  logic rd_ptr_reg, overrun_reg, push, pop, wr_ptr;

  assign head = fifo_mem[rd_ptr_reg];
  assign wr_ptr = rd_ptr_reg ^ fifo_cnt_reg[0];
  assign push = rx_done & ~overrun_reg &
                (fifo_cnt_reg != `FIFO_DEPTH);
  assign pop = bus_fire & ~we_i & (idx == `IDX_RCV_FIFO) &
               (fifo_cnt_reg != 2'h0);

  always_ff @(posedge clk_i) begin
    if (push) begin
      fifo_mem[wr_ptr] <= '{framing_error: 1'b0,
                            receive_ninth_bit: rx_word[8],
                            data: rx_word[7:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_cnt_reg <= 2'h0;
      rd_ptr_reg <= 1'b0;
    end else begin
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        fifo_cnt_reg <= fifo_cnt_reg + 2'h1;
      end else if (pop && !push) begin
        fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
      end
    end
  end

  // Set wins over the clear so an overflow on the clearing edge is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overrun_reg <= 1'b0;
    end else if (rx_done && fifo_cnt_reg == `FIFO_DEPTH) begin
      overrun_reg <= 1'b1;
    end else if (cont_clear || !port_enable_reg) begin
      overrun_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_enable_reg <= 1'b0;
      nine_bit_receive_reg <= 1'b0;
      single_rx_reg <= 1'b0;
      cont_rx_reg <= 1'b0;
      clock_source_select_reg <= 1'b0;
      nine_bit_transmit_reg <= 1'b0;
      transmit_enable_reg <= 1'b0;
      clocked_mode_reg <= 1'b0;
      transmit_ninth_bit_reg <= 1'b0;
      baud_divisor_reg <= `RST_BAUD;
      irq_enable_reg <= `RST_IRQ_EN;
    end else begin
      if (rx_done && !cont_rx_reg) begin
        single_rx_reg <= 1'b0;
      end
      if (wr_fire) begin
        case (idx)
          `IDX_RCV_STAT: begin
            port_enable_reg <= dat_i[`RS_PORT_EN];
            nine_bit_receive_reg <= dat_i[`RS_NINE_RX];
            single_rx_reg <= dat_i[`RS_SINGLE];
            cont_rx_reg <= dat_i[`RS_CONT];
          end
          `IDX_TX_STAT: begin
            clock_source_select_reg <= dat_i[`TS_CLK_SRC];
            nine_bit_transmit_reg <= dat_i[`TS_NINE_TX];
            transmit_enable_reg <= dat_i[`TS_TX_EN];
            clocked_mode_reg <= dat_i[`TS_SYNC];
            transmit_ninth_bit_reg <= dat_i[`TS_BIT9];
          end
          `IDX_BAUD: baud_divisor_reg <= dat_i[7:0];
          `IDX_IRQ_EN: irq_enable_reg <= dat_i[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register reads and acknowledge
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      `IDX_RCV_STAT: begin
        rd_byte[`RS_PORT_EN] = port_enable_reg;
        rd_byte[`RS_NINE_RX] = nine_bit_receive_reg;
        rd_byte[`RS_SINGLE] = single_rx_reg;
        rd_byte[`RS_CONT] = cont_rx_reg;
        rd_byte[`RS_FRAME] = head.framing_error;
        rd_byte[`RS_OVERRUN] = overrun_reg;
        rd_byte[`RS_BIT9] = head.receive_ninth_bit;
      end
      `IDX_RCV_FIFO: rd_byte = head.data;
      `IDX_TX_STAT: begin
        rd_byte[`TS_CLK_SRC] = clock_source_select_reg;
        rd_byte[`TS_NINE_TX] = nine_bit_transmit_reg;
        rd_byte[`TS_TX_EN] = transmit_enable_reg;
        rd_byte[`TS_SYNC] = clocked_mode_reg;
        rd_byte[`TS_SHIFT_EMPTY] = ~tx_busy_reg;
        rd_byte[`TS_BIT9] = transmit_ninth_bit_reg;
      end
      `IDX_TX_BUF: rd_byte = tx_buf_reg;
      `IDX_BAUD: rd_byte = baud_divisor_reg;
      `IDX_IRQ_FLAGS: begin
        rd_byte[`IRQ_BUF_EMPTY] = ~tx_buf_full_reg;
        rd_byte[`IRQ_DATA_READY] = fifo_cnt_reg != 2'h0;
      end
      `IDX_IRQ_EN: rd_byte = irq_enable_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= cyc_i & stb_i & ~ack_reg;
      dat_reg <= {24'h000000, rd_byte};
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign clock_pin_o = sck_reg;
  assign clock_pin_en_n_o = clk_en_n_reg;
  assign data_pin_o = data_out_reg;
  assign data_pin_en_n_o = dat_en_n_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_load;
    tx_load ##1 (tx_busy_reg && !tx_buf_full_reg);
  endsequence

  sequence s_word_in;
    push ##1 (fifo_cnt_reg != 2'h0);
  endsequence

  AST_HALF_DUPLEX: assert property (rx_on |=> data_pin_en_n_o)
    else $error("data pin driven while receiving");
  AST_LOAD_SETS_EMPTY: assert property (
    tx_load && !(wr_fire && idx == `IDX_TX_BUF) |-> s_load)
    else $error("buffer not emptied on shifter load");
  AST_WRITE_FILLS: assert property (
    wr_fire && idx == `IDX_TX_BUF |=> tx_buf_full_reg)
    else $error("buffer write did not clear empty flag");
  AST_ABORT_FLOATS: assert property (
    !transmit_enable_reg && !rx_on |=> !tx_busy_reg ##0
    clock_pin_en_n_o && data_pin_en_n_o)
    else $error("pins not floated after transmit disable");
  AST_BRG_HELD: assert property (
    !brg_run |=> !clock_pin_o && baud_cnt_reg == $past(baud_divisor_reg))
    else $error("baud generator not held");
  AST_OVERRUN_SET: assert property (
    rx_done && fifo_cnt_reg == `FIFO_DEPTH && !cont_clear |=> overrun_reg)
    else $error("overrun not flagged");
  AST_OVERRUN_BLOCKS: assert property (
    overrun_reg && !pop |=> $stable(fifo_cnt_reg))
    else $error("FIFO moved during overrun");
  AST_SINGLE_DONE: assert property (
    rx_done && !cont_rx_reg && !wr_fire |=> !single_rx_reg)
    else $error("single receive not cleared");
  AST_READY_FLAG: assert property (push |-> s_word_in)
    else $error("data-ready not set after push");
  AST_BIT_ON_RISE: assert property (
    !data_pin_en_n_o && $changed(data_pin_o) |-> $rose(clock_pin_o))
    else $error("data changed away from rising clock");

endmodule

/* File: sim/usart_slave_model.sv */
`timescale 1ns/10ps
module usart_slave_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Shift clock as seen on the wire
  input wire logic sck_i,
  input wire logic sck_en_n_i,
  // Data from the port
  input wire logic sdi_i,
  input wire logic sdi_en_n_i,
  // Word to send, restart, captured bits
  input wire logic [7:0] tx_word_i,
  input wire logic load_i,
  output logic sdo_o,
  output logic [8:0] rx_word_o,
  output logic [7:0] rx_count_o
);
  logic sck_q;
  logic fall;
  logic [2:0] idx;
  logic junk;

  assign fall = sck_q & ~sck_i & ~sck_en_n_i;
  // Outside a receive the line shows a changing pattern, never a stale bit
  assign sdo_o = (sdi_en_n_i & ~sck_en_n_i) ? tx_word_i[idx] : junk;

  always_ff @(posedge clk_i) begin
    sck_q <= sck_i;
    junk <= ~junk;
    if (rst_i | load_i) begin
      idx <= 3'h0;
      rx_count_o <= 8'h00;
      rx_word_o <= 9'h000;
      junk <= 1'b0;
    end else if (fall) begin
      if (sdi_en_n_i) begin
        // Next bit goes up right after the fall the port sampled on
        idx <= idx + 3'h1;
      end else begin
        rx_word_o <= {sdi_i, rx_word_o[8:1]};
        rx_count_o <= rx_count_o + 8'h01;
      end
    end
  end
endmodule

/* File: sim/usart_sync_master_port_test.sv */
`timescale 1ns/10ps
module usart_sync_master_port_test;
  localparam logic [7:0] RS = 8'h4C, FI = 8'h50, TS = 8'h54;
  localparam logic [7:0] TB = 8'h58, BD = 8'h5C, FL = 8'hD8, IE = 8'hDC;
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_s;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, load = 0;
  logic [7:0] adr = 8'h00, tx_word = 8'h00, q;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, dat_o;
  logic ack_o, ck, ck_en_n, d_in, d_out, d_en_n, sdo;
  logic [8:0] rx_word;
  logic [7:0] rx_count;
  integer n_errors = 0, total_checks = 0;
  row_s rows [9] = '{
    '{0, RS, 8'h00, 8'h00}, '{0, TS, 8'h00, 8'h02}, '{0, FL, 8'h00, 8'h02},
    '{0, IE, 8'h00, 8'h00}, '{0, BD, 8'h00, 8'h00}, '{1, BD, 8'hA5, 8'hA5},
    '{1, IE, 8'h03, 8'h03}, '{1, FL, 8'h00, 8'h02}, '{1, 8'h00, 8'hFF, 8'h00}};

  always #20 clk_i = ~clk_i;
  // Wire level: the port wins while it drives, else the slave
  assign d_in = d_en_n ? sdo : d_out;

  usart_sync_master_port DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(dat_o), .ack_o(ack_o), .clock_pin_o(ck),
    .clock_pin_en_n_o(ck_en_n), .data_pin_i(d_in), .data_pin_o(d_out),
    .data_pin_en_n_o(d_en_n));
  usart_slave_model slave (.clk_i(clk_i), .rst_i(rst_i), .sck_i(ck),
    .sck_en_n_i(ck_en_n), .sdi_i(d_out), .sdi_en_n_i(d_en_n),
    .tx_word_i(tx_word), .load_i(load), .sdo_o(sdo),
    .rx_word_o(rx_word), .rx_count_o(rx_count));

  task automatic give_verdict;
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    integer i;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 50);
    if (i >= 50) n_errors++;
    q = dat_o[7:0];
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask

  task automatic tick(input integer n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic restart_slave;
    @(posedge clk_i);
    load <= 1;
    @(posedge clk_i);
    load <= 0;
  endtask

  task automatic wait_cnt(input logic [7:0] n);
    integer i;
    i = 0;
    while (rx_count !== n && i < 600) begin
      @(posedge clk_i);
      i++;
    end
  endtask

  task automatic wait_bit(input logic [7:0] a, m, v);
    integer i;
    i = 0;
    do begin
      wb(0, a, 8'h00);
      i++;
    end while ((q & m) !== v && i < 300);
  endtask

  initial begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    give_verdict;
  end

  initial begin
    tick(2);
    rst_i <= 0;
    foreach (rows[k]) begin
      if (rows[k].w) wb(1, rows[k].a, rows[k].d);
      wb(0, rows[k].a, 8'h00);
      chk(q, rows[k].e);
    end
    // Back-to-back words, half period of four clocks; the buffer is
    // filled before sending is enabled so no idle clock fall is counted
    wb(1, BD, 8'h03);
    wb(1, RS, 8'h80);
    wb(1, TS, 8'h90);
    restart_slave;
    wb(1, TB, 8'hA5);
    wb(1, TS, 8'hB0);
    tick(3);
    chk(ck_en_n, 0);
    wb(1, TB, 8'h3C);
    wb(0, FL, 8'h00);
    chk(q, 8'h00);
    wb(0, TS, 8'h00);
    chk(q, 8'hB0);
    wait_cnt(8);
    chk(rx_word[8:1], 8'hA5);
    wait_cnt(16);
    chk(rx_word[8:1], 8'h3C);
    wait_bit(TS, 8'h02, 8'h02);
    chk(q, 8'hB2);
    wb(0, FL, 8'h00);
    chk(q, 8'h02);
    // Nine-bit word, ninth bit set before the data byte
    wb(1, TS, 8'hD1);
    restart_slave;
    wb(1, TB, 8'h5A);
    wb(1, TS, 8'hF1);
    wait_cnt(9);
    chk(rx_word, 9'h15A);
    wait_bit(TS, 8'h02, 8'h02);
    // Abort by clearing transmit enable
    wb(1, TS, 8'hB0);
    wb(1, TB, 8'hFF);
    tick(20);
    wb(1, TS, 8'h90);
    tick(3);
    chk({ck_en_n, d_en_n}, 2'b11);
    wb(0, TS, 8'h00);
    chk(q, 8'h92);
    // Single receive
    tx_word <= 8'h96;
    restart_slave;
    wb(1, RS, 8'hA0);
    tick(3);
    chk({ck_en_n, d_en_n}, 2'b01);
    wait_bit(FL, 8'h01, 8'h01);
    wb(0, RS, 8'h00);
    chk(q, 8'h80);
    wb(0, FI, 8'h00);
    chk(q, 8'h96);
    wb(0, FL, 8'h00);
    chk(q & 8'h01, 8'h00);
    // Continuous receive until overrun
    tx_word <= 8'h3C;
    restart_slave;
    wb(1, RS, 8'hB0);
    wait_bit(RS, 8'h02, 8'h02);
    chk(q, 8'hB2);
    wb(0, FI, 8'h00);
    chk(q, 8'h3C);
    wb(0, FI, 8'h00);
    chk(q, 8'h3C);
    // Let another word finish: overrun must keep it out of the FIFO
    tick(80);
    wb(0, FL, 8'h00);
    chk(q & 8'h01, 8'h00);
    wb(1, RS, 8'h80);
    wb(0, RS, 8'h00);
    chk(q, 8'h80);
    // Single receive breaks into a transfer, sending then resumes
    tx_word <= 8'h00;
    wb(1, TS, 8'hB0);
    wb(1, TB, 8'hFF);
    tick(12);
    restart_slave;
    wb(1, RS, 8'hA0);
    tick(3);
    chk({ck_en_n, d_en_n}, 2'b01);
    wait_bit(RS, 8'h20, 8'h00);
    tick(3);
    chk(d_en_n, 0);
    wb(0, FI, 8'h00);
    chk(q, 8'h00);
    // Reset in mid-run
    rst_i <= 1;
    tick(2);
    rst_i <= 0;
    tick(1);
    chk({ck_en_n, d_en_n}, 2'b11);
    wb(0, IE, 8'h00);
    chk(q, 8'h00);
    wb(0, TS, 8'h00);
    chk(q, 8'h02);
    give_verdict;
  end
endmodule
